// >>> rtl/pcrc_top.sv
`timescale 1ns/1ns
module pcrc_top
    import pcrc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic shift_run,
    input wire logic [3:0] poly_len_minus1,
    input wire logic [15:0] poly_taps_reg,
    input wire logic idle_stop_bit,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_byte_en,
    output logic [15:0] crc_result,
    output logic [4:0] fifo_word_count,
    output logic fifo_full_flag,
    output logic fifo_empty_flag,
    output logic crc_done,
    output logic crc_irq
);
    typedef enum logic [1:0] {PCRC_IDLE, PCRC_FETCH, PCRC_SHIFT} pcrc_state_t;

    logic [15:0] crc_q, crc_d, sh_q, sh_d, mem_rd;
    logic [4:0] cnt_q, cnt_d, depth;
    logic [3:0] wp_q, wp_d, rp_q, rp_d, bits_q, bits_d;
    logic [3:0] tail_q, tail_d;
    logic [3:0] fa_q, fa_d, rd_addr;
    logic done_q, done_d, irq_q, irq_d, active, top_lane, push, pop;
    logic [15:0] word_mask, load_word;
    pcrc_state_t st_q, st_d;

    // Halt for sleep or idle-with-stop
    assign active = !sleep_mode && !(idle_mode && idle_stop_bit);
    assign depth = (poly_len_minus1 > PCRC_LEN_SPLIT) ? PCRC_DEPTH_LONG
                                                      : PCRC_DEPTH_SHORT;
    assign top_lane = (poly_len_minus1 > PCRC_LEN_SPLIT) ? wr_byte_en[1]
                                                         : wr_byte_en[0];
    assign word_mask = 16'hFFFF >> (4'hF - poly_len_minus1);
    assign load_word = wr_data & word_mask;
    assign wr_ready = active;
    assign push = wr_valid && active && top_lane;
    // A write into a full FIFO wraps it, so nothing is taken then
    assign pop = active && shift_run && cnt_q != PCRC_CNT_RST
                 && st_q == PCRC_IDLE
                 && !(push && cnt_q == depth);
    // Fetch address held so a halt in fetch keeps the read word
    assign rd_addr = pop ? rp_q : fa_q;

    pcrc_fifo_mem u_mem (
        .clk(clk),
        .wr_en(push),
        .wr_addr(wp_q),
        .wr_data(load_word),
        .rd_addr(rd_addr),
        .rd_data(mem_rd)
    );

    // One-bit LFSR step, applied twice per clock in SHIFT but once on the last clock of an odd width, feedback at stage len
    function automatic logic [15:0] step(input logic [15:0] c,
                                         input logic b,
                                         input logic [3:0] len,
                                         input logic [15:0] taps);
        logic fb;
        logic [15:0] n;
        fb = c[len] ^ b;
        n = {c[14:0], 1'b0};
        n[0] = fb;
        n = n ^ ({taps[15:1], 1'b0} & {16{fb}});
        step = n & (16'hFFFF >> (4'hF - len));
    endfunction : step

    always_comb begin
        cnt_d = cnt_q;
        wp_d = wp_q;
        rp_d = rp_q;
        st_d = st_q;
        sh_d = sh_q;
        crc_d = crc_q;
        bits_d = bits_q;
        tail_d = tail_q;
        fa_d = fa_q;
        done_d = 1'b0;
        irq_d = 1'b0;
        if (active) begin
            if (push) begin
                wp_d = (wp_q + 4'h1) & (depth[3:0] - 4'h1);
                if (cnt_q == depth) begin
                    cnt_d = PCRC_CNT_RST;
                    rp_d = wp_d;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            case (st_q)
                PCRC_IDLE: begin
                    if (pop) begin
                        rp_d = (rp_q + 4'h1) & (depth[3:0] - 4'h1);
                        fa_d = rp_q;
                        cnt_d = push ? cnt_q : cnt_q - 5'h01;
                        irq_d = cnt_q == 5'h01 && !push;
                        st_d = PCRC_FETCH;
                    end
                end
                PCRC_FETCH: begin
                    sh_d = mem_rd;
                    bits_d = poly_len_minus1;
                    st_d = PCRC_SHIFT;
                end
                PCRC_SHIFT: begin
                    // Odd widths end on a single bit, not a padded pair
                    crc_d = step(crc_q, sh_q[bits_q], poly_len_minus1,
                        poly_taps_reg);
                    if (bits_q != 4'h0) begin
                        crc_d = step(crc_d, sh_q[bits_q - 4'h1],
                            poly_len_minus1, poly_taps_reg);
                    end
                    if (bits_q <= 4'h1) begin
                        st_d = PCRC_IDLE;
                        tail_d = (cnt_q == PCRC_CNT_RST) ? 4'h1 : 4'h0;
                    end else begin
                        bits_d = bits_q - 4'h2;
                    end
                end
                default: st_d = PCRC_IDLE;
            endcase
            if (tail_q != 4'h0 && st_q == PCRC_IDLE && !pop) begin
                done_d = 1'b1;
                tail_d = 4'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= PCRC_CNT_RST;
            wp_q <= 4'h0;
            rp_q <= 4'h0;
            st_q <= PCRC_IDLE;
            sh_q <= PCRC_CRC_RST;
            crc_q <= PCRC_CRC_RST;
            bits_q <= 4'h0;
            tail_q <= 4'h0;
            fa_q <= 4'h0;
            done_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            st_q <= st_d;
            sh_q <= sh_d;
            crc_q <= crc_d;
            bits_q <= bits_d;
            tail_q <= tail_d;
            fa_q <= fa_d;
            done_q <= done_d;
            irq_q <= irq_d;
        end
    end

    assign crc_result = crc_q;
    assign fifo_word_count = cnt_q;
    assign fifo_full_flag = cnt_q == depth;
    assign fifo_empty_flag = cnt_q == PCRC_CNT_RST;
    assign crc_done = done_q;
    assign crc_irq = irq_q;

    a_irq_on_drain: assert property (@(posedge clk) disable iff (reset)
        crc_irq |-> $past(cnt_q) == 5'h01 && cnt_q == 5'h00)
        else $error("irq without drain");
    a_wrap_full: assert property (@(posedge clk) disable iff (reset)
        push && !pop && cnt_q == depth |=> cnt_q == 5'h00 && !crc_irq)
        else $error("no wrap");
    a_pop_dec: assert property (@(posedge clk) disable iff (reset)
        pop && !push |=> cnt_q == $past(cnt_q) - 5'h01)
        else $error("no decrement");
    a_push_inc: assert property (@(posedge clk) disable iff (reset)
        push && !pop && cnt_q < depth |=> cnt_q == $past(cnt_q) + 5'h01)
        else $error("no increment");
    a_stop_run: assert property (@(posedge clk) disable iff (reset)
        !shift_run && st_q == PCRC_IDLE |=> st_q == PCRC_IDLE)
        else $error("ran while off");
    a_halt_frz: assert property (@(posedge clk) disable iff (reset)
        !active |=> $stable(cnt_q) && $stable(crc_q))
        else $error("moved while halted");
    a_empty_flag: assert property (@(posedge clk) disable iff (reset)
        push && !pop && cnt_q == 5'h00 |=> !fifo_empty_flag)
        else $error("empty flag wrong");
    a_full_flag: assert property (@(posedge clk) disable iff (reset)
        push && !pop && cnt_q == depth - 5'h01 |=> fifo_full_flag)
        else $error("full flag wrong");
    a_done_pulse: assert property (@(posedge clk) disable iff (reset)
        crc_done |=> !crc_done)
        else $error("done too long");
    sequence s_word_taken;
        pop;
    endsequence
    sequence s_word_fetched;
        st_q == PCRC_FETCH;
    endsequence
    a_pop_fetch: assert property (@(posedge clk) disable iff (reset)
        s_word_taken |=> s_word_fetched)
        else $error("no fetch after pop");
    a_depth_max: assert property (@(posedge clk) disable iff (reset)
        cnt_q <= 5'h10)
        else $error("count over depth");
endmodule : pcrc_top

// >>> inc/pcrc_pkg.sv
package pcrc_pkg;
    localparam int PCRC_LEN_W = 4;
    localparam int PCRC_DATA_W = 16;
    localparam int PCRC_CNT_W = 5;
    localparam int PCRC_DEPTH_MAX = 16;
    localparam logic [4:0] PCRC_DEPTH_LONG = 5'h08;
    localparam logic [4:0] PCRC_DEPTH_SHORT = 5'h10;
    localparam logic [3:0] PCRC_LEN_SPLIT = 4'h7;
    localparam logic [4:0] PCRC_CNT_RST = 5'h00;
    localparam logic [15:0] PCRC_CRC_RST = 16'h0000;
    localparam logic [3:0] PCRC_LEN_RST = 4'h0;
    localparam logic [15:0] PCRC_TAPS_RST = 16'h0000;
    localparam int PCRC_BITS_PER_CLK = 2;
endpackage : pcrc_pkg

// >>> rtl/pcrc_fifo_mem.sv
`timescale 1ns/1ns
module pcrc_fifo_mem
    import pcrc_pkg::*;
(
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [3:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [PCRC_DEPTH_MAX];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : pcrc_fifo_mem

// >>> bench/pcrc_test.sv
`timescale 1ns/1ns
module pcrc_test;
    import pcrc_pkg::*;
    logic clk = 0, reset = 1, shift_run = 0, idle_stop_bit = 0;
    logic idle_mode = 0, sleep_mode = 0, wr_valid = 0;
    logic [3:0] poly_len_minus1 = 4'hF;
    logic [15:0] poly_taps_reg = 16'h0000, wr_data = 16'h0000;
    logic [1:0] wr_byte_en = 2'h3;
    logic wr_ready, fifo_full_flag, fifo_empty_flag, crc_done, crc_irq;
    logic [15:0] crc_result;
    logic [4:0] fifo_word_count;
    logic [15:0] feed_crc;
    int bad_count = 0, tests_run = 0, cyc = 0, irqs = 0, k, n;
    pcrc_top pcrc_top_i (.clk(clk), .reset(reset), .shift_run(shift_run),
        .poly_len_minus1(poly_len_minus1), .poly_taps_reg(poly_taps_reg),
        .idle_stop_bit(idle_stop_bit), .idle_mode(idle_mode),
        .sleep_mode(sleep_mode), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .wr_byte_en(wr_byte_en), .crc_result(crc_result),
        .fifo_word_count(fifo_word_count), .fifo_full_flag(fifo_full_flag),
        .fifo_empty_flag(fifo_empty_flag), .crc_done(crc_done),
        .crc_irq(crc_irq));
    always #2 clk = ~clk;
    task close_out;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (crc_irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out;
        end
    end
    task chk(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk
    // Serial reference, MSB first, x^0 always fed back
    function logic [15:0] crc_ref(logic [15:0] c, logic [15:0] d, int len,
                                  logic [15:0] t);
        logic fb;
        logic [15:0] m;
        m = 16'hFFFF >> (15 - len);
        for (int i = len; i >= 0; i--) begin
            fb = c[len] ^ d[i];
            c = (c << 1) & m;
            if (fb) c = c ^ ((t & m & 16'hFFFE) | 16'h0001);
        end
        return c;
    endfunction : crc_ref
    task rst;
        @(negedge clk);
        reset = 1;
        repeat (4) @(negedge clk);
        reset = 0;
    endtask : rst
    task put(logic [15:0] d, logic [1:0] be);
        @(negedge clk);
        wr_valid = 1;
        wr_data = d;
        wr_byte_en = be;
        @(negedge clk);
        wr_valid = 0;
    endtask : put
    task fill(int cnt, logic [1:0] be);
        repeat (cnt) put(16'hFFA5, be);
        @(negedge clk);
    endtask : fill
    task run(int len, logic [15:0] t, logic [15:0] d0, logic [15:0] d1);
        logic [15:0] e;
        logic in_win;
        e = crc_ref(crc_ref(16'h0000, d0, len, t), d1, len, t);
        poly_len_minus1 = len[3:0];
        poly_taps_reg = t;
        put(d0, 2'h3);
        put(d1, 2'h3);
        @(negedge clk);
        chk("count", fifo_word_count, 16'h2);
        n = irqs;
        shift_run = 1;
        for (k = 0; k < 200 && crc_irq !== 1'b1; k++) @(negedge clk);
        chk("count at irq", fifo_word_count, 16'h0);
        for (k = 0; k < 200 && crc_done !== 1'b1; k++) @(negedge clk);
        // Fetch and the done register add two cycles, and odd widths one more shift
        in_win = k >= (len + 1) / 2 && k <= (len + 1) / 2 + 3;
        chk("done delay", in_win, 16'h1);
        chk("crc", crc_result, e);
        chk("empty", fifo_empty_flag, 16'h1);
        chk("irq count", 16'(irqs - n), 16'h1);
        shift_run = 0;
    endtask : run
    initial begin
        rst;
        chk("empty", fifo_empty_flag, 16'h1);
        chk("crc", crc_result, 16'h0000);
        run(15, 16'h1020, 16'h1234, 16'hBEEF);
        rst;
        run(5, 16'h0012, 16'hFFEA, 16'h0315);
        rst;
        run(10, 16'h0405, 16'h0123, 16'h7FF0);
        rst;
        poly_len_minus1 = 4'hF;
        poly_taps_reg = 16'h1020;
        feed_crc = 16'h0000;
        repeat (4) feed_crc = crc_ref(feed_crc, 16'hFFA5, 15, 16'h1020);
        for (int j = 0; j < 6; j++)
            feed_crc = crc_ref(feed_crc, 16'h1357 + 16'(j), 15, 16'h1020);
        n = irqs;
        repeat (4) put(16'hFFA5, 2'h3);
        shift_run = 1;
        for (int j = 0; j < 6; j++) begin
            for (k = 0; k < 200 && fifo_word_count >= 5'h08; k++)
                @(negedge clk);
            put(16'h1357 + 16'(j), 2'h3);
        end
        for (k = 0; k < 400 && fifo_empty_flag !== 1'b1; k++)
            @(negedge clk);
        for (k = 0; k < 200 && crc_done !== 1'b1; k++)
            @(negedge clk);
        chk("feed crc", crc_result, feed_crc);
        chk("feed irq", 16'(irqs - n), 16'h1);
        shift_run = 0;
        rst;
        n = irqs;
        fill(8, 2'h3);
        chk("full", fifo_full_flag, 16'h1);
        fill(1, 2'h3);
        chk("wrap", fifo_word_count, 16'h0);
        chk("wrap irq", 16'(irqs - n), 16'h0);
        poly_len_minus1 = 4'h7;
        fill(15, 2'h1);
        chk("full", fifo_full_flag, 16'h0);
        fill(1, 2'h1);
        chk("count", fifo_word_count, 16'h10);
        chk("full", fifo_full_flag, 16'h1);
        rst;
        fill(1, 2'h2);
        chk("count", fifo_word_count, 16'h0);
        fill(1, 2'h1);
        repeat (10) @(negedge clk);
        chk("count", fifo_word_count, 16'h1);
        sleep_mode = 1;
        shift_run = 1;
        fill(1, 2'h1);
        chk("count", fifo_word_count, 16'h1);
        sleep_mode = 0;
        idle_mode = 1;
        idle_stop_bit = 1;
        @(negedge clk);
        chk("ready", wr_ready, 16'h0);
        shift_run = 0;
        idle_stop_bit = 0;
        fill(1, 2'h1);
        chk("count", fifo_word_count, 16'h2);
        shift_run = 1;
        for (k = 0; k < 200 && fifo_empty_flag !== 1'b1; k++)
            @(negedge clk);
        for (k = 0; k < 200 && crc_done !== 1'b1; k++)
            @(negedge clk);
        feed_crc = crc_ref(crc_ref(16'h0000, 16'h00A5, 7, poly_taps_reg),
                           16'h00A5, 7, poly_taps_reg);
        chk("flush crc", crc_result, feed_crc);
        close_out;
    end
endmodule : pcrc_test
